// *** src/hwr_pkg.sv ***
// package: constants and types for the halt/wake/watchdog reset controller
`default_nettype none
package hwr_pkg;
  localparam int          STARTUP_CYCLES  = 1024;
  localparam int          WDT_BASE_DIV    = 256;
  localparam int          RATIO_W         = 3;
  localparam logic [7:0]  PORT_RST        = 8'hff;
  localparam logic [7:0]  IRQ_CTRL_RST    = 8'h00;
  localparam logic [7:0]  WDOG_SEL_RST    = 8'h07;
  localparam logic [11:0] PC_RST          = 12'h000;
  localparam logic [2:0]  SP_TOP          = 3'h0;
  localparam logic [2:0]  SP_ZERO         = 3'h0;

  typedef enum logic [1:0] {
    HWR_RUN   = 2'b00,
    HWR_HALT  = 2'b01,
    HWR_DELAY = 2'b11,
    HWR_POR   = 2'b10
  } hwr_state_type;

  typedef struct packed {
    logic       timeout_flag;
    logic       powerdown_flag;
  } hwr_flags_type;

  typedef struct packed {
    logic       chip_reset;
    logic       warm_reset;
    logic       wake_next;
    logic       wake_irq;
  } hwr_events_type;
endpackage : hwr_pkg
`default_nettype wire

// *** src/hwr_ctrl.sv ***
// halt, wake, watchdog and reset controller for a small 8-bit core
// How it works
// - watchdog overflow while running gives a full chip reset and sets timeout
// - watchdog overflow while halted gives a warm reset of pc and sp only
// - watchdog and prescaler clear on reset pin low after power-up, kick, or halt
// - single-kick option clears the watchdog on every kick
// - two-kick option clears only after both first and second kicks
// - halt stops the system clock; watchdog oscillator keeps running if selected
// - halt preserves ram, registers and port states
// - halt with watchdog oscillator clock restarts watchdog from zero
// - halt sets powerdown and clears timeout
// - halt ends on reset pin, interrupt, enabled port a fall, watchdog overflow
// - powerdown clears on power-up and on every kick that clears the watchdog
// - each port a line is a wake source by option; resumes next instruction
// - interrupt wake resumes next instruction if disabled or stack full
// - crystal clock waits 1024 cycles after wake; rc resumes at once
// - flags per cause: por 00, pin run uu, pin halt 01, wdt 1u, 11
// - startup delay on power-up and on crystal wake, skipped for reset-pin resets
// - chip reset sets pc 0, interrupts off, watchdog clear except after power-up, ports input, sp top
// - non-warm reset loads ports ff, interrupt_control_reg 00, watchdog select 07
// - watchdog oscillator clock is first divided by 256
// - three-bit ratio divides further from 1:1 up to 1:128
`timescale 1ns/1ns
`default_nettype none
module hwr_ctrl #(
  parameter int STARTUP_CYCLES = hwr_pkg::STARTUP_CYCLES,
  parameter int PC_W           = 12
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_external_clear_n,
  input  wire logic                 i_watchdog_tick,
  input  wire logic                 i_opt_wdt_enable,
  input  wire logic                 i_opt_wdt_osc_src,
  input  wire logic                 i_opt_single_kick,
  input  wire logic                 i_opt_crystal,
  input  wire logic [7:0]           i_opt_wake_mask,
  input  wire logic [7:0]           i_port_a,
  input  wire logic                 i_watchdog_kick,
  input  wire logic                 i_watchdog_kick_first,
  input  wire logic                 i_watchdog_kick_second,
  input  wire logic                 i_halt,
  input  wire logic                 i_irq,
  input  wire logic                 i_irq_enabled,
  input  wire logic                 i_stack_full,
  input  wire logic [7:0]           i_watchdog_select_wr,
  input  wire logic                 i_watchdog_select_we,
  output logic                      o_timeout_flag,
  output logic                      o_powerdown_flag,
  output logic                      o_sys_clk_en,
  output logic                      o_core_run,
  output logic                      o_halted,
  output logic                      o_chip_reset,
  output logic                      o_warm_reset,
  output logic                      o_wake_irq,
  output logic [PC_W-1:0]           o_program_counter_rst,
  output logic [2:0]                o_stack_pointer_rst,
  output logic [7:0]                o_port_rst,
  output logic [7:0]                o_interrupt_control_reg_rst,
  output logic [7:0]                o_watchdog_select_reg
);
  localparam int CNT_W = $clog2(STARTUP_CYCLES + 1);
  localparam int WDT_W = $clog2(hwr_pkg::WDT_BASE_DIV) + (1 << hwr_pkg::RATIO_W) - 1;
  localparam logic [CNT_W-1:0] START_LAST = CNT_W'(STARTUP_CYCLES - 1);

  typedef struct packed {
    hwr_pkg::hwr_state_type state;
    hwr_pkg::hwr_flags_type flags;
    logic [1:0]             rst_sync;
    logic                   rst_seen;
    logic [WDT_W-1:0]       watchdog_counter;
    logic                   kick1_seen;
    logic [CNT_W-1:0]       startup_delay_timer;
    logic [7:0]             port_a_prev;
    logic [7:0]             watchdog_select_reg;
    logic                   pending_irq;
    hwr_pkg::hwr_events_type ev;
  } hwr_st_type;

  hwr_st_type st;
  hwr_st_type next_st;

  logic [WDT_W-1:0] wdt_limit;
  logic             wdt_overflow;
  logic             wdt_clear;
  logic             pin_low;
  logic             pin_fall;
  logic [7:0]       port_fall;
  logic             port_wake;
  logic             tick_ok;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // timeout length: 256 base stages times 2**ratio
    wdt_limit    = WDT_W'((hwr_pkg::WDT_BASE_DIV << st.watchdog_select_reg[hwr_pkg::RATIO_W-1:0])
                          - 1);
    // system-clock source stops counting in halt; the oscillator source does not
    tick_ok      = i_opt_wdt_enable && i_watchdog_tick &&
                   ((st.state != hwr_pkg::HWR_HALT) || i_opt_wdt_osc_src);
    wdt_overflow = tick_ok && (st.watchdog_counter == wdt_limit);
    pin_low      = !st.rst_sync[1];
    pin_fall     = pin_low && st.rst_seen;
    port_fall    = st.port_a_prev & ~i_port_a & i_opt_wake_mask;
    port_wake    = |port_fall;
    wdt_clear    = 1'b0;

    next_st                     = st;
    next_st.rst_sync            = {st.rst_sync[0], i_external_clear_n};
    next_st.rst_seen            = st.rst_sync[1];
    next_st.port_a_prev         = i_port_a;
    next_st.ev                  = '0;

    // kicks only count in run; the first kick may come before or with the second
    if (st.state == hwr_pkg::HWR_RUN && i_watchdog_kick_first && !i_opt_single_kick) begin
      next_st.kick1_seen = 1'b1;
    end
    if (st.state == hwr_pkg::HWR_RUN && i_opt_single_kick && i_watchdog_kick) begin
      wdt_clear = 1'b1;
    end
    if (st.state == hwr_pkg::HWR_RUN && !i_opt_single_kick && i_watchdog_kick_second &&
        (st.kick1_seen || i_watchdog_kick_first)) begin
      wdt_clear          = 1'b1;
      next_st.kick1_seen = 1'b0;
    end
    if (wdt_clear) begin
      next_st.flags.timeout_flag   = 1'b0;
      next_st.flags.powerdown_flag = 1'b0;
    end

    case (st.state)
      hwr_pkg::HWR_POR: begin
        // power-up: delay then chip reset with flags 00
        next_st.startup_delay_timer = st.startup_delay_timer + CNT_W'(1);
        if (st.startup_delay_timer == START_LAST) begin
          next_st.state     = hwr_pkg::HWR_RUN;
          next_st.ev.chip_reset = 1'b1;
        end
      end
      hwr_pkg::HWR_RUN: begin
        if (pin_low) begin
          // pin reset in run: flags unchanged, no startup delay
          next_st.ev.chip_reset = pin_fall;
          wdt_clear             = 1'b1;
          next_st.kick1_seen    = 1'b0;
        end else if (wdt_overflow) begin
          // an overflow in the cycle of a kick still resets: the set wins over the clear
          next_st.ev.chip_reset       = 1'b1;
          next_st.flags.timeout_flag  = 1'b1;
          wdt_clear                   = 1'b1;
          next_st.kick1_seen          = 1'b0;
        end else if (i_halt) begin
          next_st.state                = hwr_pkg::HWR_HALT;
          next_st.flags.powerdown_flag = 1'b1;
          next_st.flags.timeout_flag   = 1'b0;
          wdt_clear                    = 1'b1;
          next_st.kick1_seen           = 1'b0;
        end
      end
      hwr_pkg::HWR_HALT: begin
        next_st.startup_delay_timer = '0;
        if (pin_low) begin
          next_st.ev.chip_reset      = 1'b1;
          next_st.flags.timeout_flag = 1'b0;
          next_st.flags.powerdown_flag = 1'b1;
          next_st.state              = hwr_pkg::HWR_RUN;
          wdt_clear                  = 1'b1;
        end else if (wdt_overflow || i_irq || port_wake) begin
          if (wdt_overflow) begin
            next_st.flags.timeout_flag = 1'b1;
            next_st.ev.warm_reset      = !i_opt_crystal;
            wdt_clear                  = 1'b1;
          end
          next_st.pending_irq = !wdt_overflow && i_irq && i_irq_enabled && !i_stack_full;
          next_st.ev.wake_irq  = !i_opt_crystal && next_st.pending_irq;
          next_st.ev.wake_next = !i_opt_crystal && !wdt_overflow && !next_st.pending_irq;
          next_st.state        = i_opt_crystal ? hwr_pkg::HWR_DELAY : hwr_pkg::HWR_RUN;
        end
      end
      hwr_pkg::HWR_DELAY: begin
        next_st.startup_delay_timer = st.startup_delay_timer + CNT_W'(1);
        if (pin_low) begin
          next_st.ev.chip_reset = 1'b1;
          next_st.state         = hwr_pkg::HWR_RUN;
          wdt_clear             = 1'b1;
        end else if (st.startup_delay_timer == START_LAST) begin
          next_st.state        = hwr_pkg::HWR_RUN;
          next_st.ev.warm_reset = st.flags.timeout_flag;
          next_st.ev.wake_irq  = st.pending_irq && !st.flags.timeout_flag;
          next_st.ev.wake_next = !st.pending_irq && !st.flags.timeout_flag;
        end
      end
      default: begin
        next_st.state = hwr_pkg::HWR_POR;
      end
    endcase

    if (wdt_clear) begin
      next_st.watchdog_counter = '0;
    end else if (tick_ok) begin
      next_st.watchdog_counter = st.watchdog_counter + WDT_W'(1);
    end

    if (next_st.ev.chip_reset) begin
      next_st.watchdog_select_reg = hwr_pkg::WDOG_SEL_RST;
      next_st.pending_irq         = 1'b0;
    end else if (i_watchdog_select_we && st.state == hwr_pkg::HWR_RUN) begin
      next_st.watchdog_select_reg = i_watchdog_select_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st                     <= '0;
      st.state               <= hwr_pkg::HWR_POR;
      st.rst_sync            <= 2'b11;
      st.rst_seen            <= 1'b1;
      st.port_a_prev         <= hwr_pkg::PORT_RST;
      st.watchdog_select_reg <= hwr_pkg::WDOG_SEL_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset values are offered to the core alongside the reset pulses
  assign o_timeout_flag              = st.flags.timeout_flag;
  assign o_powerdown_flag            = st.flags.powerdown_flag;
  assign o_sys_clk_en                = (st.state != hwr_pkg::HWR_HALT);
  assign o_core_run                  = (st.state == hwr_pkg::HWR_RUN) && !pin_low;
  assign o_halted                    = (st.state == hwr_pkg::HWR_HALT);
  assign o_chip_reset                = st.ev.chip_reset;
  assign o_warm_reset                = st.ev.warm_reset;
  assign o_wake_irq                  = st.ev.wake_irq;
  assign o_program_counter_rst       = PC_W'(hwr_pkg::PC_RST);
  assign o_stack_pointer_rst         = st.ev.warm_reset ? hwr_pkg::SP_ZERO : hwr_pkg::SP_TOP;
  assign o_port_rst                  = hwr_pkg::PORT_RST;
  assign o_interrupt_control_reg_rst = hwr_pkg::IRQ_CTRL_RST;
  assign o_watchdog_select_reg       = st.watchdog_select_reg;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_halt_enter;
    st.state == hwr_pkg::HWR_RUN && !pin_low && !wdt_overflow && i_halt;
  endsequence

  a_halt_flags: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_halt_enter |=> o_powerdown_flag && !o_timeout_flag && o_halted)
    else $error("halt did not set powerdown and clear timeout");
  a_halt_wdt_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_halt_enter |=> st.watchdog_counter == '0)
    else $error("watchdog not cleared on halt");
  a_run_overflow: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st.state == hwr_pkg::HWR_RUN && !pin_low && wdt_overflow |=> o_chip_reset && o_timeout_flag)
    else $error("run overflow missed chip reset");
  a_pin_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    pin_low && st.state != hwr_pkg::HWR_POR |=> st.watchdog_counter == '0)
    else $error("reset pin did not clear watchdog");
  a_kick_powerdown: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st.state == hwr_pkg::HWR_RUN && i_opt_single_kick && i_watchdog_kick && !pin_low && !i_halt
    |=> !o_powerdown_flag)
    else $error("kick did not clear powerdown");
  a_halt_clk_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_halted |-> !o_sys_clk_en && !o_core_run)
    else $error("clock runs in halt");
  // seven idle cycles hold for any startup delay of eight cycles or more
  a_crystal_delay: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(st.state == hwr_pkg::HWR_DELAY) |=> !o_core_run [*7])
    else $error("core resumed during startup delay");
  a_wdt_halt_wake: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_halted && !pin_low && wdt_overflow |=> o_timeout_flag && o_powerdown_flag)
    else $error("watchdog wake flags wrong");
  a_pin_halt: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_halted && pin_low |=> o_chip_reset && !o_timeout_flag && o_powerdown_flag && !o_halted)
    else $error("reset pin did not wake halt");
  a_ratio_limit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st.watchdog_select_reg[2:0] == 3'h0 |-> wdt_limit == WDT_W'(8'hff))
    else $error("ratio 1:1 limit wrong");

  // a pin reset in run sends one reset pulse and leaves both flags alone
  sequence s_pin_run_fall;
    st.state == hwr_pkg::HWR_RUN && pin_fall && !i_watchdog_kick && !i_watchdog_kick_second;
  endsequence

  sequence s_port_wake_rc;
    o_halted && st.rst_sync[0] && !pin_low && !wdt_overflow && !i_irq && port_wake && !i_opt_crystal;
  endsequence

  a_pin_run_reset: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_pin_run_fall |=> o_chip_reset && $stable(st.flags))
    else $error("reset pin in run disturbed the flags");
  a_port_resume: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_port_wake_rc |=> o_core_run && !o_chip_reset && !o_warm_reset && !o_wake_irq)
    else $error("port wake did not resume in place");
  a_warm_keeps_sel: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_warm_reset |-> $stable(o_watchdog_select_reg))
    else $error("warm reset changed watchdog select");
  a_por_delay: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st.state == hwr_pkg::HWR_POR && st.startup_delay_timer != START_LAST |=> !o_core_run && !o_chip_reset)
    else $error("power-up left the startup delay early");
endmodule : hwr_ctrl
`default_nettype wire

// *** tb/tb.sv ***
// self-checking testbench for the halt, wake, watchdog and reset controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module tb;
  // short startup delay keeps the run brief; some startup-delay waits below are derived from it, others are fixed counts
  localparam int SU = 8;
  logic        i_clk, i_rst_b, i_external_clear_n, i_watchdog_tick, i_opt_wdt_enable, i_opt_wdt_osc_src;
  logic        i_opt_single_kick, i_opt_crystal, i_watchdog_kick, i_watchdog_kick_first, i_watchdog_kick_second;
  logic        i_halt, i_irq, i_irq_enabled, i_stack_full, i_watchdog_select_we;
  logic [7:0]  i_opt_wake_mask, i_port_a, i_watchdog_select_wr;
  logic        o_timeout_flag, o_powerdown_flag, o_sys_clk_en, o_core_run, o_halted;
  logic        o_chip_reset, o_warm_reset, o_wake_irq;
  logic [11:0] o_program_counter_rst;
  logic [2:0]  o_stack_pointer_rst;
  logic [7:0]  o_port_rst, o_interrupt_control_reg_rst, o_watchdog_select_reg;
  int          n_errors, n_tests, n_chip, n_warm, n_wirq, cyc;

  hwr_ctrl #(.STARTUP_CYCLES(SU), .PC_W(12)) uut (
    .i_clk, .i_rst_b, .i_external_clear_n, .i_watchdog_tick, .i_opt_wdt_enable, .i_opt_wdt_osc_src,
    .i_opt_single_kick, .i_opt_crystal, .i_opt_wake_mask, .i_port_a, .i_watchdog_kick,
    .i_watchdog_kick_first, .i_watchdog_kick_second, .i_halt, .i_irq, .i_irq_enabled, .i_stack_full,
    .i_watchdog_select_wr, .i_watchdog_select_we, .o_timeout_flag, .o_powerdown_flag, .o_sys_clk_en,
    .o_core_run, .o_halted, .o_chip_reset, .o_warm_reset, .o_wake_irq, .o_program_counter_rst,
    .o_stack_pointer_rst, .o_port_rst, .o_interrupt_control_reg_rst, .o_watchdog_select_reg);

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // one-cycle pulses are counted here so no scenario can miss one between its checks
  always @(posedge i_clk) begin
    cyc++;
    if (o_chip_reset === 1'b1) n_chip++;
    if (o_warm_reset === 1'b1) n_warm++;
    if (o_wake_irq === 1'b1) n_wirq++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) begin
      @(posedge i_clk);
      #1;
    end
  endtask : step

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pulse

  // ticks are spaced one idle cycle apart, as a slow oscillator would deliver them
  task automatic ticks(input int n);
    repeat (n) begin
      i_watchdog_tick = 1'b1;
      step(1);
      i_watchdog_tick = 1'b0;
      step(1);
    end
  endtask : ticks

  task automatic wsel(input logic [7:0] v);
    i_watchdog_select_wr = v;
    pulse(i_watchdog_select_we);
  endtask : wsel

  task automatic pin_reset();
    i_external_clear_n = 1'b0;
    step(4);
    i_external_clear_n = 1'b1;
    step(4);
  endtask : pin_reset

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_watchdog_tick, i_watchdog_kick, i_watchdog_kick_first, i_watchdog_kick_second} = 4'h0;
    {i_halt, i_irq, i_irq_enabled, i_stack_full, i_watchdog_select_we, i_opt_crystal} = 6'h00;
    {i_opt_wdt_enable, i_opt_wdt_osc_src, i_opt_single_kick, i_external_clear_n} = 4'hf;
    i_opt_wake_mask = 8'h04;
    i_port_a = 8'hff;
    i_watchdog_select_wr = 8'h00;
    i_rst_b = 1'b0;
    step(3);
    i_rst_b = 1'b1;
    step(SU - 2);
    `CHK("early chip reset", 0, n_chip)
    step(8);
    `CHK("power-up chip reset", 1, n_chip)
    `CHK("core running", 1'b1, o_core_run)
    `CHK("flags", 2'h0, {o_timeout_flag, o_powerdown_flag})
    `CHK("select", 8'h07, o_watchdog_select_reg)
    `CHK("port", 8'hff, o_port_rst)
    `CHK("irq control", 8'h00, o_interrupt_control_reg_rst)
    `CHK("pc sp", 15'h0000, {o_program_counter_rst, o_stack_pointer_rst})
    // single kick clears the count; 256 ticks at 1:1 then overflow
    wsel(8'h00);
    `CHK("select write", 8'h00, o_watchdog_select_reg)
    ticks(200);
    pulse(i_watchdog_kick);
    ticks(200);
    `CHK("kicked no reset", 1, n_chip)
    ticks(70);
    step(4);
    `CHK("overflow run", 2, n_chip)
    `CHK("flags", 2'h2, {o_timeout_flag, o_powerdown_flag})
    `CHK("select", 8'h07, o_watchdog_select_reg)
    // two-kick option: second kick alone does not clear
    i_opt_single_kick = 1'b0;
    wsel(8'h00);
    ticks(200);
    pulse(i_watchdog_kick_second);
    ticks(100);
    step(4);
    `CHK("lone second kick", 3, n_chip)
    // 58 ticks are left over from the overflow; 150 more stay below the limit
    wsel(8'h00);
    ticks(150);
    pulse(i_watchdog_kick_first);
    pulse(i_watchdog_kick_second);
    ticks(200);
    `CHK("kick pair", 3, n_chip)
    // halt, then wake from an enabled port a line only
    pulse(i_halt);
    `CHK("halted", 1'b1, o_halted)
    `CHK("flags", 2'h1, {o_timeout_flag, o_powerdown_flag})
    `CHK("clock off", 1'b0, o_sys_clk_en)
    i_port_a = 8'hfe;
    step(3);
    `CHK("masked line", 1'b1, o_halted)
    i_port_a = 8'hfa;
    step(2);
    `CHK("port wake", 2'h2, {o_core_run, o_halted})
    `CHK("no reset", 3, n_chip)
    i_port_a = 8'hff;
    pulse(i_watchdog_kick_first);
    pulse(i_watchdog_kick_second);
    step(1);
    `CHK("kick clears powerdown", 1'b0, o_powerdown_flag)
    // overflow in halt with crystal: warm reset; halt restarted the count
    i_opt_single_kick = 1'b1;
    i_opt_crystal = 1'b1;
    ticks(200);
    pulse(i_halt);
    ticks(200);
    `CHK("halt restarted", 2'h1, {n_warm[0], o_halted})
    ticks(70);
    step(SU + 4);
    `CHK("warm reset", 4'h3, {n_warm[3:0] - 4'h1, 4'h0} | n_chip[3:0])
    `CHK("flags", 2'h3, {o_timeout_flag, o_powerdown_flag})
    `CHK("select kept", 8'h00, o_watchdog_select_reg)
    // interrupt wake with crystal waits the startup delay
    i_irq_enabled = 1'b1;
    pulse(i_halt);
    pulse(i_irq);
    step(SU - 3);
    `CHK("still waiting", 1'b0, o_core_run)
    step(6);
    `CHK("irq wake", 2'h3, {o_core_run, n_wirq[0]})
    // rc clock: wake at once; only an enabled interrupt with stack room is serviced
    i_opt_crystal = 1'b0;
    for (int k = 0; k < 3; k++) begin
      {i_irq_enabled, i_stack_full} = (k == 0) ? 2'h0 : (k == 1) ? 2'h3 : 2'h2;
      pulse(i_halt);
      pulse(i_irq);
      step(2);
      `CHK("rc wake", (k == 2) ? 3'h6 : 3'h5, {o_core_run, n_wirq[1:0]})
    end
    i_stack_full = 1'b0;
    // reset pin during halt, then during run
    wsel(8'h00);
    pulse(i_halt);
    pin_reset();
    `CHK("pin wake", 5'h04, {o_halted, n_chip[3:0]})
    `CHK("flags", 2'h1, {o_timeout_flag, o_powerdown_flag})
    `CHK("select", 8'h07, o_watchdog_select_reg)
    pin_reset();
    `CHK("pin run", 5'h15, {o_core_run, n_chip[3:0]})
    `CHK("flags kept", 2'h1, {o_timeout_flag, o_powerdown_flag})
    // instruction-clock source: the watchdog sleeps with the core, so no warm reset
    wsel(8'h00);
    i_opt_wdt_osc_src = 1'b0;
    pulse(i_halt);
    ticks(300);
    `CHK("no count in halt", 5'h11, {o_halted, n_warm[3:0]})
    i_port_a = 8'hfb;
    step(2);
    i_port_a = 8'hff;
    `CHK("port wake again", 1'b1, o_core_run)
    give_verdict();
  end
endmodule : tb
`default_nettype wire
